// ==== burst_port_pkg.sv ====
package burst_port_pkg;

   // Control line codes (4 bits)
   localparam logic [3:0] CODE_DATA_XFER    = 4'h2;
   localparam logic [3:0] CODE_REG_WRITE    = 4'h2;
   localparam logic [3:0] CODE_PIPE_NO_OP   = 4'hE;
   localparam logic [3:0] CODE_NORM_NO_OP   = 4'hF;
   localparam logic [3:0] CODE_BURST_ADDR   = 4'hC;
   localparam logic [3:0] CODE_REG_ADDR_MIN = 4'h8;

   // Burst size codes on limit/read/write lines
   localparam logic [2:0] SIZE_4   = 3'h6;
   localparam logic [2:0] SIZE_8   = 3'h5;
   localparam logic [2:0] SIZE_16  = 3'h4;
   localparam logic [2:0] SIZE_32  = 3'h3;
   localparam logic [2:0] SIZE_64  = 3'h2;
   localparam logic [2:0] SIZE_128 = 3'h1;
   localparam logic [2:0] SIZE_256 = 3'h0;

   // Bytes per 32-bit word
   localparam int WORD_BYTES = 4;

   // Reset values
   localparam logic [3:0] DEMAND_IDLE   = 4'hF;
   localparam logic [2:0] CEILING_RESET = 3'h0;

   // Port states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE      = 5'b00001,
      ST_REQ       = 5'b00010,
      ST_SIZE      = 5'b00100,
      ST_BURST     = 5'b01000,
      ST_END_BURST = 5'b10000
   } port_state_e;

   // Word handed from the transfer engine
   typedef struct packed {
      logic [31:0] data;
      logic        last;
   } xfer_word_s;

endpackage : burst_port_pkg

// ==== word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             i_clk,
   input  wire logic             i_reset,
   // Fill side
   input  wire logic             i_in_valid,
   output logic                  o_in_ready,
   input  wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic                  o_out_valid,
   input  wire logic             i_out_ready,
   output logic [WIDTH-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   wire              push = i_in_valid && o_in_ready;
   wire              pop  = o_out_valid && i_out_ready;

   // Honest flags straight from the occupancy count
   assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data  = mem_r[rd_ptr_r];

   // Storage
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   // Pointers and count
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : word_fifo
`default_nettype wire

// ==== burst_port_ctrl.sv ====
// Summary of operation
// R01 - A burst is a declaration access followed by individual data accesses.
// R02 - Burst address access drives the address and the size code on upper lines.
// R03 - Size is the least of ceiling, remaining count and address limit.
// R04 - Size codes 4..256 bytes map to 110 down to 000; code loads limit.
// R05 - Direction stays locked until limit expires or a pipeline no-op arrives.
// R06 - Burst mode lines: limit, read demand, write demand, data valid.
// R07 - Limit held asserted; counts down on data accesses; negated at zero.
// R08 - Limit negation is external end; direction switching allowed again.
// R09 - Data valid only for consecutive same-page next address; else ignore data.
// R10 - Bus logic may stretch a word with wait; port continues until burst end.
// R11 - After internal end, bus logic no-ops out or accesses to limit.
// R12 - No-op aborts burst; two no-ops needed before reversing direction.
// R13 - Outbound with internal end first, trailing accesses drive all ones.
// R14 - Five states: idle, request, size, burst, end of burst.
// R15 - End of burst ignores data accesses, lines keep burst meaning.
// R16 - Two-cycle access: wait negated, code changes in second clock.
// R17 - Register write: address then write code; data written at second edge.
// R18 - Port error: bus logic turns data code into odd code under wait.
// R19 - Address-port register updates only under that port's wait.
// R20 - Inbound DMA: address wait lags data wait by one clock.
// R21 - Outbound DMA: address wait equals data wait.
// R22 - Pipeline no-op enters pipeline mode; normal no-op returns to normal.
// R23 - Wait sampled at rising edge; negated wait suppresses internal edge.
// R24 - Leaving burst by no-op restores normal lines and clears the lock.
`timescale 1ns/1ps
`default_nettype none
module burst_port_ctrl #(
   parameter int       FIFO_DEPTH = 8,
   parameter int       PAGE_BITS  = 12,
   parameter int       CNT_W      = 16
) (
   // Clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_reset,
   // External bus control
   input  wire logic [3:0]        i_control_lines,
   input  wire logic              i_data_port_wait,
   input  wire logic              i_address_port_wait,
   input  wire logic [31:0]       i_data_port_bus,
   // Port outputs
   output logic [3:0]             o_demand_lines,
   output logic [31:0]            o_data_port_bus,
   output logic                   o_data_port_oe,
   output logic [31:0]            o_address_port_bus,
   output logic                   o_pipeline_mode,
   output logic                   o_reg_write,
   output logic [3:0]             o_reg_write_addr,
   output logic [31:0]            o_reg_write_data,
   output logic                   o_port_error,
   // Internal transfer engine
   input  wire logic              i_xfer_outbound,
   input  wire logic              i_xfer_pending,
   input  wire logic [CNT_W-1:0]  i_xfer_remaining,
   input  wire logic [31:0]       i_xfer_addr,
   input  wire logic              i_addr_limit_en,
   input  wire logic [2:0]        i_burst_size_ceiling,
   input  wire logic              i_next_consecutive,
   input  wire logic              i_word_valid,
   output logic                   o_word_ready,
   input  wire logic [31:0]       i_word_data,
   output logic                   o_in_valid,
   input  wire logic              i_in_ready,
   output logic [31:0]            o_in_data
);
   burst_port_pkg::port_state_e state_r;
   burst_port_pkg::port_state_e state_nxt;
   logic [8:0]  limit_cnt_r;
   logic        lock_r;
   logic        dir_out_r;
   logic        nop_seen_r;
   logic        first_cyc_r;
   logic [3:0]  prev_code_r;
   logic        int_end_r;

   // Code decode; wait high means ready, low stretches the access
   wire         edge_en   = i_data_port_wait;                             // R23
   wire         is_pipeline_no_op   = (i_control_lines == burst_port_pkg::CODE_PIPE_NO_OP);
   wire         is_nop    = (i_control_lines == burst_port_pkg::CODE_NORM_NO_OP);
   wire         is_burst_address_access   = (i_control_lines == burst_port_pkg::CODE_BURST_ADDR);
   wire         is_data   = (i_control_lines == burst_port_pkg::CODE_DATA_XFER);
   wire         in_burst  = (state_r == burst_port_pkg::ST_BURST) || (state_r == burst_port_pkg::ST_END_BURST);
   wire         limit_hit = (limit_cnt_r == 9'h000);

   // Size selection: smallest of ceiling, remaining bytes and page limit
   wire [8:0]   rem_bytes = (i_xfer_remaining > CNT_W'(256)) ? 9'h100 : i_xfer_remaining[8:0];
   wire [12:0]  page_room = 13'(1 << PAGE_BITS) - 13'(i_xfer_addr[PAGE_BITS-1:0]);
   wire [8:0]   pg_bytes  = (!i_addr_limit_en || page_room > 13'h0100) ? 9'h100 : page_room[8:0];
   wire [8:0]   ceil_b    = 9'(9'h100 >> i_burst_size_ceiling);
   wire [8:0]   min_a     = (ceil_b < rem_bytes) ? ceil_b : rem_bytes;
   wire [8:0]   min_bytes = (min_a < pg_bytes) ? min_a : pg_bytes;                        // R03
   wire [2:0]   size_code = (min_bytes >= 9'h100) ? burst_port_pkg::SIZE_256 :
                            (min_bytes >= 9'h080) ? burst_port_pkg::SIZE_128 :
                            (min_bytes >= 9'h040) ? burst_port_pkg::SIZE_64 :
                            (min_bytes >= 9'h020) ? burst_port_pkg::SIZE_32 :
                            (min_bytes >= 9'h010) ? burst_port_pkg::SIZE_16 :
                            (min_bytes >= 9'h008) ? burst_port_pkg::SIZE_8 :
                                                    burst_port_pkg::SIZE_4;               // R04
   wire [8:0]   size_words = 9'(9'h040 >> size_code);

   // Data access accepted only outside the internal end
   wire         data_acc  = edge_en && is_data && !int_end_r
                            && (state_r != burst_port_pkg::ST_END_BURST);                 // R09 R15
   wire         out_fill  = data_acc && dir_out_r;

   // Outbound words pass through the FIFO; a full FIFO stalls the engine
   logic                       fifo_valid;
   burst_port_pkg::xfer_word_s fifo_in;
   burst_port_pkg::xfer_word_s fifo_data;
   assign fifo_in = '{data: i_word_data, last: !i_next_consecutive};
   word_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_in_valid  (i_word_valid),
      .o_in_ready  (o_word_ready),
      .i_in_data   (fifo_in),
      .o_out_valid (fifo_valid),
      .i_out_ready (out_fill),
      .o_out_data  (fifo_data)
   );

   // Counting edge; the lines look ahead so limit and valid answer with no lag
   wire         cnt_step  = edge_en && is_data && (in_burst || state_r == burst_port_pkg::ST_SIZE);
   wire         last_step = cnt_step && (limit_cnt_r == 9'h001);
   wire         end_step  = cnt_step && (dir_out_r ? (fifo_valid && fifo_data.last)
                                                   : (!i_next_consecutive || i_xfer_remaining <= CNT_W'(1)));

   // State transitions
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         burst_port_pkg::ST_IDLE: begin
            if (edge_en && is_pipeline_no_op && i_xfer_pending) state_nxt = burst_port_pkg::ST_REQ;   // R14
         end
         burst_port_pkg::ST_REQ: begin
            if (edge_en && is_burst_address_access) state_nxt = burst_port_pkg::ST_SIZE;                  // R01 R14
            else if (edge_en && is_pipeline_no_op && !i_xfer_pending) state_nxt = burst_port_pkg::ST_IDLE;
         end
         burst_port_pkg::ST_SIZE: begin
            if (edge_en && is_pipeline_no_op) state_nxt = burst_port_pkg::ST_REQ;
            else if (edge_en && is_data && !limit_hit) state_nxt = burst_port_pkg::ST_BURST; // R14
         end
         burst_port_pkg::ST_BURST: begin
            if (edge_en && is_pipeline_no_op) state_nxt = burst_port_pkg::ST_REQ;                   // R12 R24
            else if (edge_en && is_data && int_end_r) state_nxt = burst_port_pkg::ST_END_BURST;
         end
         burst_port_pkg::ST_END_BURST: begin
            if (edge_en && is_pipeline_no_op) state_nxt = burst_port_pkg::ST_REQ;                   // R11
         end
         default: state_nxt = burst_port_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (i_reset) state_r <= burst_port_pkg::ST_IDLE;
      else         state_r <= state_nxt;
   end

   // Mode, lock and limit counter
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_pipeline_mode <= 1'b0;
         lock_r          <= 1'b0;
         limit_cnt_r     <= 9'h000;
         dir_out_r       <= 1'b0;
         nop_seen_r      <= 1'b0;
         int_end_r       <= 1'b0;
      end else if (edge_en) begin
         if (is_pipeline_no_op) o_pipeline_mode <= 1'b1;                                            // R22
         else if (is_nop) o_pipeline_mode <= 1'b0;                                        // R22
         if (is_burst_address_access && state_r == burst_port_pkg::ST_REQ) begin
            limit_cnt_r <= size_words;                                                    // R04
            lock_r      <= 1'b1;                                                          // R05
            int_end_r   <= 1'b0;
         end else if (is_pipeline_no_op) begin
            lock_r      <= 1'b0;                                                          // R05 R24
            limit_cnt_r <= 9'h000;
            int_end_r   <= 1'b0;
         end else if (cnt_step) begin
            if (!limit_hit) limit_cnt_r <= limit_cnt_r - 9'h001;                          // R07
            if (last_step) lock_r <= 1'b0;                                                // R08
            if (end_step) int_end_r <= 1'b1;                                              // R09
         end
         // Direction changes only after two no-ops and never while locked
         nop_seen_r <= is_pipeline_no_op;
         if (is_pipeline_no_op && nop_seen_r && !lock_r) dir_out_r <= i_xfer_outbound;              // R12
      end
   end

   // Two-cycle access tracking
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         first_cyc_r <= 1'b0;
         prev_code_r <= 4'h0;
      end else begin
         first_cyc_r <= !i_data_port_wait;                                                // R16
         prev_code_r <= i_control_lines;
      end
   end

   // Register write and error report
   wire prev_regadr = (prev_code_r >= burst_port_pkg::CODE_REG_ADDR_MIN)
                      && (prev_code_r != burst_port_pkg::CODE_PIPE_NO_OP)
                      && (prev_code_r != burst_port_pkg::CODE_NORM_NO_OP)
                      && (prev_code_r != burst_port_pkg::CODE_BURST_ADDR);
   wire register_write_code_hit   = first_cyc_r && prev_regadr && (i_control_lines == burst_port_pkg::CODE_REG_WRITE); // R17
   wire err_hit     = first_cyc_r && (prev_code_r == burst_port_pkg::CODE_DATA_XFER)
                      && i_control_lines[0];                                              // R18

   // Registered side outputs
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_reg_write      <= 1'b0;
         o_reg_write_addr <= 4'h0;
         o_reg_write_data <= 32'h0000_0000;
         o_port_error     <= 1'b0;
         o_in_valid       <= 1'b0;
         o_in_data        <= 32'h0000_0000;
      end else begin
         o_reg_write <= register_write_code_hit && o_pipeline_mode;
         if (register_write_code_hit) begin
            o_reg_write_addr <= prev_code_r;
            o_reg_write_data <= i_data_port_bus;                                          // R17
         end
         o_port_error <= err_hit;
         if (i_in_ready) o_in_valid <= data_acc && !dir_out_r && !register_write_code_hit;             // R10
         if (data_acc && !dir_out_r) o_in_data <= i_data_port_bus;                        // R23
      end
   end

   // Demand lines: normal meaning outside burst, size code in the size state, burst meaning inside
   wire       lock_after  = lock_r && !last_step;
   wire [3:0] burst_lines = {~(lock_after && !limit_hit), ~(lock_after && dir_out_r),
                             ~(lock_after && !dir_out_r), int_end_r || end_step};          // R06 R07
   wire [3:0] norm_lines  = (state_r == burst_port_pkg::ST_IDLE) ? burst_port_pkg::DEMAND_IDLE
                            : {1'b1, ~dir_out_r, dir_out_r, 1'b1};
   wire [3:0] size_lines  = {size_code, 1'b1};

   // Data bus and demand line drive
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_demand_lines     <= burst_port_pkg::DEMAND_IDLE;
         o_data_port_bus    <= 32'h0000_0000;
         o_data_port_oe     <= 1'b0;
         o_address_port_bus <= 32'h0000_0000;
      end else begin
         if (state_nxt == burst_port_pkg::ST_SIZE && state_r == burst_port_pkg::ST_REQ)
            o_demand_lines <= size_lines;                                                 // R02
         else if (state_nxt == burst_port_pkg::ST_BURST || state_nxt == burst_port_pkg::ST_END_BURST)
            o_demand_lines <= burst_lines;                                                // R15
         else if (state_nxt != burst_port_pkg::ST_SIZE)
            o_demand_lines <= norm_lines;                                                 // R24
         if (edge_en) begin
            if (is_burst_address_access && state_r == burst_port_pkg::ST_REQ) o_data_port_bus <= i_xfer_addr;   // R02
            else if (is_data && dir_out_r && (int_end_r || state_r == burst_port_pkg::ST_END_BURST)
                     && !limit_hit) o_data_port_bus <= 32'hFFFF_FFFF;                     // R13
            else if (out_fill) o_data_port_bus <= fifo_data.data;
         end
         o_data_port_oe <= dir_out_r && o_pipeline_mode;
         if (i_address_port_wait) o_address_port_bus <= i_xfer_addr;                      // R19
      end
   end

   // Locked port holds its direction and limit counter only counts down
   AST_LOCK_HOLDS_DIR: assert property (@(posedge i_clk) disable iff (i_reset)
      lock_r && !(i_data_port_wait && is_pipeline_no_op) |=> $stable(dir_out_r))                    // R05
      else $error("direction changed while locked");

   AST_LIMIT_DECREMENT: assert property (@(posedge i_clk) disable iff (i_reset)
      in_burst && i_data_port_wait && is_data && !limit_hit |=> limit_cnt_r == $past(limit_cnt_r) - 9'h001) // R07
      else $error("limit counter did not count a data access");

   AST_END_IGNORES_DATA: assert property (@(posedge i_clk) disable iff (i_reset)
      state_r == burst_port_pkg::ST_END_BURST && is_data |-> !data_acc)                   // R15
      else $error("data accepted in end state");

   sequence s_req_burst_address_access;
      state_r == burst_port_pkg::ST_REQ && i_data_port_wait && is_burst_address_access;
   endsequence
   AST_SIZE_ON_LINES: assert property (@(posedge i_clk) disable iff (i_reset)
      s_req_burst_address_access |=> o_demand_lines[3:1] == $past(size_code) && lock_r)                   // R02
      else $error("size code not presented");

   AST_PIPELINE_NO_OP_CLEARS_LOCK: assert property (@(posedge i_clk) disable iff (i_reset)
      i_data_port_wait && is_pipeline_no_op |=> !lock_r && o_pipeline_mode)                         // R24
      else $error("no-op did not release lock");

   AST_NOP_NORMAL: assert property (@(posedge i_clk) disable iff (i_reset)
      i_data_port_wait && is_nop |=> !o_pipeline_mode)                                    // R22
      else $error("normal no-op kept pipeline mode");

   AST_WAIT_FREEZES: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_data_port_wait |=> $stable(state_r) && $stable(limit_cnt_r))                     // R23
      else $error("state moved under wait");

   AST_ADDR_HOLD: assert property (@(posedge i_clk) disable iff (i_reset)
      !i_address_port_wait |=> $stable(o_address_port_bus))                               // R19
      else $error("address register moved under wait");

   AST_REG_WRITE: assert property (@(posedge i_clk) disable iff (i_reset)
      register_write_code_hit && o_pipeline_mode |=> o_reg_write && o_reg_write_data == $past(i_data_port_bus)) // R17
      else $error("register write lost");
endmodule : burst_port_ctrl
`default_nettype wire

// ==== bus_glue_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module bus_glue_model (
   // Clock and transfer direction
   input  wire logic        i_clk,
   input  wire logic        i_outbound,
   // Lines towards the port
   output logic [3:0]       o_code,
   output logic             o_data_wait,
   output logic             o_addr_wait,
   output logic [31:0]      o_bus
);
   // Quiet bus, nothing taken until a task runs
   initial begin
      o_code      = 4'hF;
      o_data_wait = 1'b0;
      o_addr_wait = 1'b0;
      o_bus       = 32'h0000_0000;
   end

   // One access: c0 while stalled, then c with wait high for one edge
   task automatic access(input logic [3:0] c0, input logic [3:0] c, input logic [31:0] d, input int stall);
      for (int i = 0; i <= stall; i++) begin
         @(posedge i_clk);
         o_code      <= (i == stall) ? c : c0;
         o_bus       <= (i == stall) ? d : ~d; // Junk while stalled
         o_data_wait <= (i == stall);
         o_addr_wait <= i_outbound ? (i == stall) : ((i == stall) | o_data_wait);
      end
      @(posedge i_clk);
      o_data_wait <= 1'b0;
      o_addr_wait <= i_outbound ? 1'b0 : o_data_wait;
      o_bus       <= ~d; // Released bus must not show a stale word
      #1;
   endtask : access
endmodule : bus_glue_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, reset = 1'b1, outb, pend, lim_en, consec, wvalid, inready;
   logic [2:0]  ceil;
   logic [15:0] rem;
   logic [31:0] xaddr, wdata, bus_in, dout, abus, regw_data, indata, ab_q, w;
   logic [3:0]  demand, regw_addr, rw_a, ctl;
   logic        oe, pmode, regw, perr, wready, invalid, dwait, await, aw_q;
   wire  [31:0] gbus;
   logic [31:0] rw_d, out_q[$], in_q[$];
   int          err_count = 0, check_count = 0, cycles = 0, regw_seen = 0, perr_seen = 0, n, b, re, ea;

   // Clock, and the shared data wire resolved from both drivers
   always #5 clk = ~clk;
   assign bus_in = oe ? dout : gbus;

   burst_port_ctrl dut (.i_clk(clk), .i_reset(reset), .i_control_lines(ctl), .i_data_port_wait(dwait),
      .i_address_port_wait(await), .i_data_port_bus(bus_in), .o_demand_lines(demand), .o_data_port_bus(dout),
      .o_data_port_oe(oe), .o_address_port_bus(abus), .o_pipeline_mode(pmode), .o_reg_write(regw),
      .o_reg_write_addr(regw_addr), .o_reg_write_data(regw_data), .o_port_error(perr), .i_xfer_outbound(outb),
      .i_xfer_pending(pend), .i_xfer_remaining(rem), .i_xfer_addr(xaddr), .i_addr_limit_en(lim_en),
      .i_burst_size_ceiling(ceil), .i_next_consecutive(consec), .i_word_valid(wvalid), .o_word_ready(wready),
      .i_word_data(wdata), .o_in_valid(invalid), .i_in_ready(inready), .o_in_data(indata));
   bus_glue_model g (.i_clk(clk), .i_outbound(outb), .o_code(ctl), .o_data_wait(dwait), .o_addr_wait(await),
      .o_bus(gbus));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic final_report;
      $display("checks %0d, mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report

   // Size code of a byte count, 4 bytes being the smallest step
   function automatic logic [2:0] size_code(input int bytes);
      int k;
      k = 0;
      while ((4 << k) < bytes) k++;
      return 3'(6 - k);
   endfunction : size_code

   // Monitors: pulses, inbound words against the queue, address port hold
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         final_report();
      end
   end

   always @(posedge clk) begin
      if (regw === 1'b1) begin
         regw_seen++;
         rw_a = regw_addr;
         rw_d = regw_data;
      end
      if (perr === 1'b1) perr_seen++;
      if (invalid === 1'b1 && inready) chk(indata, in_q.size() ? in_q.pop_front() : ~indata, "inbound word");
      if (aw_q === 1'b0 && !reset) chk(abus, ab_q, "address port held");
      aw_q <= await;
      ab_q <= abus;
   end

   task automatic burst_open(input logic [2:0] c, input int r);
      @(posedge clk);
      ceil <= c;
      rem  <= 16'(r);
      g.access(4'hE, 4'hE, 32'h0000_0000, 0);
      g.access(4'hE, 4'hE, 32'h0000_0000, 0);
      g.access(4'hC, 4'hC, 32'h0000_0000, 0);
   endtask : burst_open

   initial begin
      void'($urandom(35));
      {outb, lim_en, wvalid, ceil, xaddr, wdata, aw_q, ab_q} = '0;
      {pend, consec, inready} = 3'h7;
      rem = 16'h0100;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      chk(demand, 4'hF, "idle demand");
      // Register write pairs, every address code
      g.access(4'hE, 4'hE, 32'h0000_0000, 0);
      for (int j = 0; j < 5; j++) begin
         n = regw_seen;
         w = $urandom;
         g.access(4'h8 + 4'(j == 4 ? 5 : j), 4'h2, w, 1 + $urandom % 2);
         @(posedge clk);
         #1;
         chk(regw_seen, n + 1, "write pulse");
         chk(rw_a, 4'h8 + 4'(j == 4 ? 5 : j), "write address");
         chk(rw_d, w, "write data");
      end
      chk(pmode, 1'b1, "pipeline mode");
      // Size is the least of ceiling, remaining and page limit
      for (int i = 0; i < 7; i++) begin
         re = 2 + $urandom % 7;
         ea = 2 + $urandom % 7;
         b  = 1 << (8 - i);
         if ((1 << re) < b) b = 1 << re;
         if (i[0] && (1 << ea) < b) b = 1 << ea;
         @(posedge clk);
         lim_en <= i[0];
         xaddr  <= 32'h0000_1000 - 32'(1 << ea);
         burst_open(3'(i), 1 << re);
         chk(demand, {size_code(b), 1'b1}, "size code");
         chk(dout, 32'h0000_1000 - 32'(1 << ea), "burst address");
      end
      // Outbound: fill the buffer until it refuses, drain it by a paced burst
      outb <= 1'b0;
      @(posedge clk);
      outb   <= 1'b1;
      lim_en <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         w = $urandom;
         wvalid <= 1'b1;
         wdata  <= w;
         #1;
         n = wready;
         @(posedge clk);
         if (n == 1) out_q.push_back(w);
      end
      wvalid <= 1'b0;
      #1;
      chk(out_q.size(), 8, "buffer depth");
      chk(wready, 1'b0, "buffer full");
      burst_open(3'h3, 32);
      chk(oe, 1'b1, "data bus enable");
      for (int k = 1; k <= 8; k++) begin
         g.access(4'h2, 4'h2, 32'h0000_0000, $urandom % 3);
         chk(dout, out_q.pop_front(), "outbound word");
         chk(demand[3], k == 8, "limit line");
         if (k < 8) chk(demand[0], 1'b0, "data valid");
      end
      // Inbound paced burst of 16 bytes
      outb <= 1'b0;
      burst_open(3'h4, 16);
      for (int k = 1; k <= 4; k++) begin
         w = $urandom;
         in_q.push_back(w);
         g.access(4'h2, 4'h2, w, $urandom % 3);
      end
      chk(demand[3], 1'b1, "external end");
      // Non-consecutive next word: internal end, later access ignored
      consec <= 1'b0;
      burst_open(3'h4, 16);
      w = $urandom;
      in_q.push_back(w);
      g.access(4'h2, 4'h2, w, 0);
      chk(demand[0], 1'b1, "internal end");
      g.access(4'h2, 4'h2, $urandom, 0);
      // Port error under wait during a data access
      consec <= 1'b1;
      n = perr_seen;
      burst_open(3'h4, 16);
      g.access(4'h2, 4'h3, 32'h0000_0000, 1);
      repeat (2) @(posedge clk);
      #1;
      chk(perr_seen, n + 1, "port error pulse");
      chk(in_q.size(), 0, "inbound words delivered");
      g.access(4'hF, 4'hF, 32'h0000_0000, 0);
      chk(pmode, 1'b0, "normal mode");
      final_report();
   end
endmodule : tb_top
`default_nettype wire
